//--- design/vibration_sensor_diagnostics_map.svh
`ifndef VIBRATION_SENSOR_DIAGNOSTICS_MAP_SVH
`define VIBRATION_SENSOR_DIAGNOSTICS_MAP_SVH

// byte addresses on the serial port, even byte is the low half of a word
`define ADDR_FLASH_WRITE_COUNTER 7'h00
`define ADDR_MISC_CONTROL        7'h34
`define ADDR_SELFTEST_CHANGE     7'h38
`define ADDR_DIAGNOSTIC_STATUS   7'h3C
`define ADDR_GLOBAL_COMMAND      7'h3E
`define ADDR_LOT_CODE_LOW        7'h52
`define ADDR_LOT_CODE_HIGH       7'h54
`define ADDR_UNIT_SERIAL         7'h58

// global_command bit positions
`define GLOB_SELFTEST_BIT   2
`define GLOB_CLEAR_DIAG_BIT 4
`define GLOB_FLASH_TEST_BIT 5
`define GLOB_CAPTURE_BIT    11

// diagnostic_status bit positions
`define DIAG_SUPPLY_LOW_BIT   0
`define DIAG_SUPPLY_HIGH_BIT  1
`define DIAG_FLASH_UPD_BIT    2
`define DIAG_COMM_FAIL_BIT    3
`define DIAG_VIOLATION_BIT    4
`define DIAG_SELFTEST_BIT     5
`define DIAG_FLASH_TEST_BIT   6
`define DIAG_DATA_READY_BIT   7
`define DIAG_PEAK_LSB         8
`define DIAG_RATE_ALARM_BIT   11
`define DIAG_TRIGGER_LSB      12

// misc_control bit position, misc_control and diagnostic_status reset values
`define MISC_SELFTEST_BIT 8
`define MISC_RESET        16'h0003
`define DIAG_RESET        16'h0000

// timing
`define CLK_PERIOD_NS      50
`define STARTUP_TIME_NS    100000
`define SELFTEST_TIME_NS   12000000
`define FLASHTEST_TIME_NS  10500000
`define STARTUP_CYCLES     ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- design/vsd_pkg.sv
package vsd_pkg;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_ST_SETTLE,
    ENG_ST_STIM,
    ENG_FLASH
  } engine_state_type;

  // events from the sampling and capture engine, all on CLK
  typedef struct packed {
    logic       sample_tick;
    logic       capture_start;
    logic       capture_done;
    logic       capture_busy;
    logic [2:0] trigger_source;
    logic [2:0] peak_over;
    logic       rate_alarm;
    logic       flash_write;
    logic       flash_update_fail;
  } sensor_event_type;

  // one 16-bit serial command word
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_word_type;

endpackage

//--- design/vibration_sensor_diagnostics.sv
`include "vibration_sensor_diagnostics_map.svh"

// Behaviour
// - error flags read 1 on error, 0 in normal operation.
// - flags hold until next capture start or clear-status command bit 4.
// - supply flags set again at next sample or capture while fault persists.
// - bits 14:12 record event trigger source aux2, aux1, acceleration.
// - bits 10:8 record capture peaks over alarm threshold per channel.
// - bit 11 records the rate-of-change alarm condition.
// - flash test sets bit 6 on checksum mismatch.
// - serial transfer during capture sets violation bit 4.
// - frame with edge count not multiple of 16 sets bit 3.
// - bit 7 data ready, bit 2 flash update failure, bit 15 reserved.
// - bit 1 supply above 3.625 V, bit 0 supply below 3.15 V.
// - command bit 2 runs automatic self-test, stores delta, flags bit 5.
// - misc bit 8 drives stimulus, clears itself when a capture completes.
// - misc bits 1:0 enable supply compensation, reset value 0x0003.
// - self-test delta is 16-bit two's complement acceleration.
// - 24-bit lot code, low byte in lot_code_low 15:8, rest high.
// - read-only 16-bit serial number.
// - flash write counter increments on every flash write while CE is high.
// - after supply reaches 3.15 V, start up into manual capture mode.
// - each response returns data of the previous read command.
// - command bit 5 runs flash test, about 10.5 ms.
module vibration_sensor_diagnostics
  import vsd_pkg::*;
#(
  parameter int              SELFTEST_CYCLES  = `SELFTEST_TIME_NS / `CLK_PERIOD_NS,
  parameter int              FLASHTEST_CYCLES = `FLASHTEST_TIME_NS / `CLK_PERIOD_NS,
  parameter logic signed [15:0] SELFTEST_MIN  = 16'sh0010,
  parameter logic signed [15:0] SELFTEST_MAX  = 16'sh0800
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  // serial port
  input  wire logic             SCLK,
  input  wire logic             CS_N,
  input  wire logic             DIN,
  output logic                  DOUT,
  output logic                  DOUT_OE,
  // supply comparators, asynchronous
  input  wire logic             SUPPLY_HIGH,
  input  wire logic             SUPPLY_LOW,
  // capture engine
  input  wire sensor_event_type EVENTS,
  input  wire logic [15:0]      ACCEL_SAMPLE,
  output logic                  CAPTURE_REQUEST,
  output logic                  MANUAL_CAPTURE_MODE,
  // self-test and compensation
  output logic                  SELFTEST_DRIVE,
  output logic [1:0]            SUPPLY_COMP,
  // flash
  input  wire logic [15:0]      FLASH_CHECKSUM,
  input  wire logic [15:0]      WORK_CHECKSUM,
  // identity, factory programmed
  input  wire logic [23:0]      LOT_CODE,
  input  wire logic [15:0]      UNIT_SERIAL
);

  localparam int TIMER_W = 32;
  localparam logic [TIMER_W-1:0] ST_HALF = TIMER_W'(SELFTEST_CYCLES / 2);
  localparam logic [TIMER_W-1:0] FT_END  = TIMER_W'(FLASHTEST_CYCLES);
  localparam logic [TIMER_W-1:0] SU_END  = TIMER_W'(`STARTUP_CYCLES);

  // ---------------- link side, SCLK domain ----------------
  logic        link_rst_reg;
  logic [3:0]  bit_count_reg;
  logic [15:0] shift_reg;
  logic [15:0] word_hold_reg;
  logic        word_toggle_reg;
  logic        partial_reg;
  logic        dout_bit_reg;
  logic [15:0] resp_word_reg;

  // reset for the link side, asserted asynchronously there
  always_ff @(posedge CLK) begin
    link_rst_reg <= RST;
  end

  // count restarts with every chip select, so a short frame cannot skew the next
  always_ff @(posedge SCLK or posedge link_rst_reg or posedge CS_N) begin
    if (link_rst_reg || CS_N) begin
      bit_count_reg <= 4'h0;
    end else begin
      bit_count_reg <= bit_count_reg + 4'h1;
    end
  end

  always_ff @(posedge SCLK or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      shift_reg <= 16'h0000;
    end else begin
      shift_reg <= {shift_reg[14:0], DIN};
    end
  end

  // residue survives chip select so the CLK side can judge the frame
  always_ff @(posedge SCLK or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      word_hold_reg   <= 16'h0000;
      word_toggle_reg <= 1'b0;
      partial_reg     <= 1'b0;
    end else begin
      partial_reg <= (bit_count_reg != 4'hF);
      if (bit_count_reg == 4'hF) begin
        word_hold_reg   <= {shift_reg[14:0], DIN};
        word_toggle_reg <= ~word_toggle_reg;
      end
    end
  end

  // response word only changes between frames, so it is quasi-static here
  always_ff @(negedge SCLK or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      dout_bit_reg <= 1'b0;
    end else begin
      dout_bit_reg <= resp_word_reg[~bit_count_reg];
    end
  end

  assign DOUT    = (bit_count_reg == 4'h0) ? resp_word_reg[15] : dout_bit_reg;
  assign DOUT_OE = ~CS_N;

  // ---------------- synchronisers into CLK ----------------
  logic [1:0] cs_sync_reg;
  logic [1:0] tog_sync_reg;
  logic [1:0] high_sync_reg;
  logic [1:0] low_sync_reg;
  logic       cs_prev_reg;
  logic       tog_seen_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_sync_reg   <= 2'b11;
      tog_sync_reg  <= 2'b00;
      high_sync_reg <= 2'b00;
      low_sync_reg  <= 2'b11;
      cs_prev_reg   <= 1'b1;
      tog_seen_reg  <= 1'b0;
    end else if (CE) begin
      cs_sync_reg   <= {cs_sync_reg[0], CS_N};
      tog_sync_reg  <= {tog_sync_reg[0], word_toggle_reg};
      high_sync_reg <= {high_sync_reg[0], SUPPLY_HIGH};
      low_sync_reg  <= {low_sync_reg[0], SUPPLY_LOW};
      cs_prev_reg   <= cs_sync_reg[1];
      tog_seen_reg  <= tog_sync_reg[1];
    end
  end

  logic         frame_start;
  logic         frame_end;
  logic         word_taken;
  spi_word_type cmd;
  logic         ready_reg;
  logic         glob_lo_wr;
  logic         glob_hi_wr;
  logic         misc_lo_wr;
  logic         misc_hi_wr;
  logic         cmd_selftest;
  logic         cmd_clear;
  logic         cmd_flash;
  logic         cmd_capture;

  assign frame_start = CE && cs_prev_reg && !cs_sync_reg[1];
  assign frame_end   = CE && !cs_prev_reg && cs_sync_reg[1];
  assign word_taken  = CE && (tog_sync_reg[1] != tog_seen_reg);
  assign cmd         = spi_word_type'(word_hold_reg);

  // writes are ignored until the start-up sequence has finished
  assign glob_lo_wr   = word_taken && ready_reg && cmd.write && (cmd.addr == `ADDR_GLOBAL_COMMAND);
  assign glob_hi_wr   = word_taken && ready_reg && cmd.write && (cmd.addr == (`ADDR_GLOBAL_COMMAND + 7'h01));
  assign misc_lo_wr   = word_taken && ready_reg && cmd.write && (cmd.addr == `ADDR_MISC_CONTROL);
  assign misc_hi_wr   = word_taken && ready_reg && cmd.write && (cmd.addr == (`ADDR_MISC_CONTROL + 7'h01));
  assign cmd_selftest = glob_lo_wr && cmd.data[`GLOB_SELFTEST_BIT];
  assign cmd_clear    = glob_lo_wr && cmd.data[`GLOB_CLEAR_DIAG_BIT];
  assign cmd_flash    = glob_lo_wr && cmd.data[`GLOB_FLASH_TEST_BIT];
  assign cmd_capture  = glob_hi_wr && cmd.data[`GLOB_CAPTURE_BIT - 8];

  // ---------------- start-up ----------------
  logic [TIMER_W-1:0] startup_count_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      startup_count_reg <= '0;
      ready_reg         <= 1'b0;
    end else if (CE && !ready_reg) begin
      if (low_sync_reg[1]) begin
        startup_count_reg <= '0;
      end else if (startup_count_reg == SU_END) begin
        ready_reg <= 1'b1;
      end else begin
        startup_count_reg <= startup_count_reg + 1'b1;
      end
    end
  end

  assign MANUAL_CAPTURE_MODE = ready_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      CAPTURE_REQUEST <= 1'b0;
    end else if (CE) begin
      CAPTURE_REQUEST <= cmd_capture;
    end
  end

  // ---------------- self-test and flash test engine ----------------
  engine_state_type   eng_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [15:0]        base_reg;
  logic [15:0]        selftest_change_reg;
  logic signed [15:0] st_diff;
  logic               st_fail_set;
  logic               ft_fail_set;

  assign st_diff = $signed(ACCEL_SAMPLE) - $signed(base_reg);

  always_ff @(posedge CLK) begin
    if (RST) begin
      eng_reg             <= ENG_IDLE;
      timer_reg           <= '0;
      base_reg            <= 16'h0000;
      selftest_change_reg <= 16'h0000;
      st_fail_set         <= 1'b0;
      ft_fail_set         <= 1'b0;
    end else if (CE) begin
      st_fail_set <= 1'b0;
      ft_fail_set <= 1'b0;
      timer_reg   <= timer_reg + 1'b1;
      case (eng_reg)
        ENG_IDLE: begin
          timer_reg <= '0;
          if (cmd_selftest) begin
            eng_reg <= ENG_ST_SETTLE;
          end else if (cmd_flash) begin
            eng_reg <= ENG_FLASH;
          end
        end
        ENG_ST_SETTLE: begin
          if (timer_reg >= ST_HALF) begin
            base_reg  <= ACCEL_SAMPLE;
            timer_reg <= '0;
            eng_reg   <= ENG_ST_STIM;
          end
        end
        ENG_ST_STIM: begin
          if (timer_reg >= ST_HALF) begin
            selftest_change_reg <= st_diff;
            st_fail_set         <= (st_diff < SELFTEST_MIN) || (st_diff > SELFTEST_MAX);
            eng_reg             <= ENG_IDLE;
          end
        end
        ENG_FLASH: begin
          if (timer_reg >= FT_END) begin
            ft_fail_set <= (FLASH_CHECKSUM != WORK_CHECKSUM);
            eng_reg     <= ENG_IDLE;
          end
        end
        default: eng_reg <= ENG_IDLE;
      endcase
    end
  end

  // ---------------- misc_control ----------------
  logic       misc_st_reg;
  logic [1:0] comp_reg;

  // manual stimulus ends when the capture that measures it completes
  always_ff @(posedge CLK) begin
    if (RST) begin
      comp_reg    <= 2'(`MISC_RESET);
      misc_st_reg <= 1'b0;
    end else if (CE) begin
      if (misc_lo_wr) begin
        comp_reg <= cmd.data[1:0];
      end
      if (misc_hi_wr) begin
        misc_st_reg <= cmd.data[`MISC_SELFTEST_BIT - 8];
      end else if (EVENTS.capture_done) begin
        misc_st_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SELFTEST_DRIVE <= 1'b0;
    end else if (CE) begin
      SELFTEST_DRIVE <= misc_st_reg || (eng_reg == ENG_ST_STIM);
    end
  end

  assign SUPPLY_COMP = comp_reg;

  // ---------------- diagnostic_status ----------------
  logic [15:0] diag_reg;
  logic [15:0] diag_set;
  logic        diag_clear;
  logic        supply_check;

  assign supply_check = EVENTS.sample_tick || EVENTS.capture_done;
  assign diag_clear   = cmd_clear || EVENTS.capture_start;

  always_comb begin
    diag_set = 16'h0000;
    diag_set[`DIAG_SUPPLY_LOW_BIT]  = supply_check && low_sync_reg[1];
    diag_set[`DIAG_SUPPLY_HIGH_BIT] = supply_check && high_sync_reg[1];
    diag_set[`DIAG_FLASH_UPD_BIT]   = EVENTS.flash_update_fail;
    diag_set[`DIAG_COMM_FAIL_BIT]   = frame_end && partial_reg;
    diag_set[`DIAG_VIOLATION_BIT]   = frame_start && EVENTS.capture_busy;
    diag_set[`DIAG_SELFTEST_BIT]    = st_fail_set;
    diag_set[`DIAG_FLASH_TEST_BIT]  = ft_fail_set;
    diag_set[`DIAG_DATA_READY_BIT]  = EVENTS.capture_done;
    diag_set[`DIAG_PEAK_LSB +: 3]   = EVENTS.capture_done ? EVENTS.peak_over : 3'b000;
    diag_set[`DIAG_RATE_ALARM_BIT]  = EVENTS.rate_alarm;
    diag_set[`DIAG_TRIGGER_LSB +: 3] = EVENTS.trigger_source;
  end

  // a set arriving with a clear wins, so no event is lost
  always_ff @(posedge CLK) begin
    if (RST) begin
      diag_reg <= `DIAG_RESET;
    end else if (CE) begin
      diag_reg <= (diag_clear ? 16'h0000 : diag_reg) | diag_set;
    end
  end

  // ---------------- flash write counter ----------------
  logic [15:0] flash_count_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      flash_count_reg <= 16'h0000;
    end else if (CE && EVENTS.flash_write) begin
      flash_count_reg <= flash_count_reg + 16'h0001;
    end
  end

  // ---------------- read path ----------------
  logic [6:0]  rd_addr;
  logic [15:0] read_data;

  assign rd_addr = {cmd.addr[6:1], 1'b0};

  always_comb begin
    if (rd_addr == `ADDR_DIAGNOSTIC_STATUS) begin
      read_data = diag_reg;
    end else if (rd_addr == `ADDR_MISC_CONTROL) begin
      read_data = {7'h00, misc_st_reg, 6'h00, comp_reg};
    end else if (rd_addr == `ADDR_SELFTEST_CHANGE) begin
      read_data = selftest_change_reg;
    end else if (rd_addr == `ADDR_LOT_CODE_LOW) begin
      read_data = {LOT_CODE[7:0], 8'h00};
    end else if (rd_addr == `ADDR_LOT_CODE_HIGH) begin
      read_data = LOT_CODE[23:8];
    end else if (rd_addr == `ADDR_UNIT_SERIAL) begin
      read_data = UNIT_SERIAL;
    end else if (rd_addr == `ADDR_FLASH_WRITE_COUNTER) begin
      read_data = flash_count_reg;
    end else begin
      read_data = 16'h0000;
    end
  end

  // answer goes out in the next frame; writes leave the last answer in place
  always_ff @(posedge CLK) begin
    if (RST) begin
      resp_word_reg <= 16'h0000;
    end else if (word_taken && !cmd.write) begin
      resp_word_reg <= read_data;
    end
  end

endmodule // vibration_sensor_diagnostics

//--- tb/vibration_sensor_diagnostics_checker.sv
module vibration_sensor_diagnostics_checker
  import vsd_pkg::*;
(
  // clock and reset
  input wire logic             CLK,
  input wire logic             RST,
  // serial port
  input wire logic             CS_N,
  input wire logic             DOUT_OE,
  // supply and events
  input wire logic             SUPPLY_LOW,
  input wire sensor_event_type EVENTS,
  // control outputs
  input wire logic             CAPTURE_REQUEST,
  input wire logic             MANUAL_CAPTURE_MODE,
  input wire logic             SELFTEST_DRIVE,
  input wire logic [1:0]       SUPPLY_COMP
);
  localparam int STARTUP_MIN = 2000;
  int unsigned since_reset;
  int unsigned low_run;
  // counters saturate so long runs never wrap
  always_ff @(posedge CLK) begin
    if (RST) since_reset <= 0;
    else if (since_reset < 100000) since_reset <= since_reset + 1;
  end
  always_ff @(posedge CLK) begin
    if (RST || SUPPLY_LOW) low_run <= 0;
    else if (low_run < 100000) low_run <= low_run + 1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_request_one_cycle: assert property (CAPTURE_REQUEST |=> !CAPTURE_REQUEST)
    else $error("capture request longer than one cycle");
  a_request_after_frame: assert property (CAPTURE_REQUEST |-> MANUAL_CAPTURE_MODE && $past(CS_N))
    else $error("capture request without finished frame or start-up");
  a_startup_wait: assert property (MANUAL_CAPTURE_MODE |-> since_reset >= STARTUP_MIN)
    else $error("manual capture mode too early after reset");
  a_startup_supply: assert property ($rose(MANUAL_CAPTURE_MODE) |-> low_run >= STARTUP_MIN)
    else $error("start-up ended without healthy supply");
  a_mode_stays: assert property (MANUAL_CAPTURE_MODE && !SUPPLY_LOW |=> MANUAL_CAPTURE_MODE)
    else $error("manual capture mode dropped");
  a_reset_outputs: assert property ($fell(RST) |-> SUPPLY_COMP == 2'b11 && !SELFTEST_DRIVE && !MANUAL_CAPTURE_MODE)
    else $error("outputs wrong after reset");
  a_enable_frame: assert property (DOUT_OE == !CS_N)
    else $error("data out enable does not follow chip select");
  a_comp_by_write: assert property ($changed(SUPPLY_COMP) |-> CS_N && $past(CS_N))
    else $error("compensation changed without a finished write");
  c_request: cover property (CAPTURE_REQUEST);
  c_startup: cover property ($rose(MANUAL_CAPTURE_MODE));
  c_stimulus: cover property ($rose(SELFTEST_DRIVE));
endmodule // vibration_sensor_diagnostics_checker

bind vibration_sensor_diagnostics vibration_sensor_diagnostics_checker u_chk (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .DOUT_OE(DOUT_OE), .SUPPLY_LOW(SUPPLY_LOW), .EVENTS(EVENTS),
  .CAPTURE_REQUEST(CAPTURE_REQUEST), .MANUAL_CAPTURE_MODE(MANUAL_CAPTURE_MODE),
  .SELFTEST_DRIVE(SELFTEST_DRIVE), .SUPPLY_COMP(SUPPLY_COMP)
);

//--- tb/spi_host_model.sv
module spi_host_model (
  // serial lines
  output logic     sclk,
  output logic     cs_n,
  output logic     din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // one word per frame, answer belongs to the previous read word; clock idles low
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rsp);
    rsp = '0;
    cs_n = 1'b0;
    #16;
    for (int i = 0; i < nbits; i++) begin
      din = cmd[15-i];
      #16;
      rsp[15-i] = dout;
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    din = ~din;
    // gap well above the 6-cycle minimum so the answer settles
    #500;
  endtask
endmodule // spi_host_model

//--- tb/tb_top.sv
`include "vibration_sensor_diagnostics_map.svh"
module tb_top;
  import vsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  logic             supply_high = 1'b0;
  logic             supply_low = 1'b1;
  logic [15:0]      flash_sum = 16'h1234;
  logic [15:0]      accel = 16'h0100;
  logic [15:0]      step = 16'h0040;
  sensor_event_type ev = '0;
  wire              sclk, cs_n, din, dout, dout_oe, cap_req, mode, drive;
  wire [1:0]        comp;
  logic [15:0]      rsp;
  int               failures = 0;
  int               checks = 0;
  int               caps = 0;

  always #25 clk = ~clk;
  // sensor answers the stimulus with a fixed step
  always @(posedge clk) accel <= drive ? 16'h0100 + step : 16'h0100;
  always @(posedge clk) if (cap_req === 1'b1) caps++;

  // lot code and serial are arbitrary values
  vibration_sensor_diagnostics #(.SELFTEST_CYCLES(20), .FLASHTEST_CYCLES(20)) u_dut (
    .CLK(clk), .RST(rst), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
    .SUPPLY_HIGH(supply_high), .SUPPLY_LOW(supply_low), .EVENTS(ev), .ACCEL_SAMPLE(accel),
    .CAPTURE_REQUEST(cap_req), .MANUAL_CAPTURE_MODE(mode), .SELFTEST_DRIVE(drive), .SUPPLY_COMP(comp),
    .FLASH_CHECKSUM(flash_sum), .WORK_CHECKSUM(16'h1234), .LOT_CODE(24'hA5C3E1), .UNIT_SERIAL(16'h5A17)
  );
  spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
    u_host.xfer({1'b0, a, 8'h00}, 16, rsp);
    u_host.xfer(16'h0000, 16, rsp);
    chk(rsp & m, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b1, a, d}, 16, rsp);
  endtask
  task automatic pulse(input logic [12:0] v);
    @(posedge clk) ev <= sensor_event_type'(v);
    @(posedge clk) ev <= '0;
  endtask
  task automatic wait_sig(input bit m, input logic lvl, input int lim);
    int n = 0;
    while (((m ? mode : drive) !== lvl) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n == lim) begin
      failures++;
      $display("FAIL %0t wait ran out", $time);
      results;
    end
  endtask
  task automatic selftest(input logic [15:0] s, input logic [15:0] diag);
    @(posedge clk) step <= s;
    wr(`ADDR_GLOBAL_COMMAND, 8'h04);
    wait_sig(0, 1'b1, 100);
    wait_sig(0, 1'b0, 100);
    repeat (4) @(posedge clk);
    rd(`ADDR_SELFTEST_CHANGE, s);
    rd(`ADDR_DIAGNOSTIC_STATUS, diag);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("FAIL %0t run too long", $time);
    results;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    pulse(13'h1000);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0001);
    wr(`ADDR_MISC_CONTROL, 8'h00);
    rd(`ADDR_MISC_CONTROL, 16'h0003);
    pulse(13'h0800);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    @(posedge clk) supply_low <= 1'b0;
    wait_sig(1, 1'b1, 3000);
    $display("test startup done");
    rd(`ADDR_LOT_CODE_LOW, 16'hE100, 16'hFF00);
    rd(`ADDR_LOT_CODE_HIGH, 16'hA5C3);
    wr(`ADDR_UNIT_SERIAL, 8'h00);
    rd(`ADDR_UNIT_SERIAL, 16'h5A17);
    wr(`ADDR_MISC_CONTROL, 8'h02);
    rd(`ADDR_MISC_CONTROL, 16'h0002);
    chk({14'h0000, comp}, 16'h0002);
    wr(`ADDR_MISC_CONTROL, 8'h03);
    $display("test identity done");
    pulse(13'h055D);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h5B84);
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    @(posedge clk) supply_high <= 1'b1;
    // the level needs two edges through the synchroniser before a sample can see it
    repeat (2) @(posedge clk);
    pulse(13'h1000);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0002);
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    pulse(13'h0400);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0082);
    @(posedge clk) supply_high <= 1'b0;
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    @(posedge clk) ev <= sensor_event_type'(13'h0200);
    u_host.xfer(16'h3C00, 16, rsp);
    @(posedge clk) ev <= '0;
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0010);
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    u_host.xfer(16'hFFFF, 15, rsp);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0008);
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    wr(7'h3F, 8'h08);
    chk(caps[15:0], 16'h0001);
    $display("test flags done");
    selftest(16'h0040, 16'h0000);
    selftest(16'hFFC0, 16'h0020);
    wr(`ADDR_GLOBAL_COMMAND, 8'h10);
    wr(7'h35, 8'h01);
    wait_sig(0, 1'b1, 20);
    rd(`ADDR_MISC_CONTROL, 16'h0103);
    pulse(13'h0400);
    rd(`ADDR_MISC_CONTROL, 16'h0003);
    chk({15'h0000, drive}, 16'h0000);
    $display("test selftest done");
    @(posedge clk) flash_sum <= 16'h1235;
    wr(`ADDR_GLOBAL_COMMAND, 8'h30);
    repeat (30) @(posedge clk);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0040);
    @(posedge clk) flash_sum <= 16'h1234;
    wr(`ADDR_GLOBAL_COMMAND, 8'h30);
    repeat (30) @(posedge clk);
    rd(`ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    // a flash write while the enable is low must not count
    @(posedge clk) ce <= 1'b0;
    pulse(13'h0002);
    @(posedge clk) ce <= 1'b1;
    repeat (3) pulse(13'h0002);
    rd(`ADDR_FLASH_WRITE_COUNTER, 16'h0003);
    $display("test flash done");
    results;
  end
endmodule // tb_top
